// ===== logic/async_serial_rx_wakeup_ctrl.sv
`timescale 1ns/1ps
module async_serial_rx_wakeup_ctrl
	import async_serial_pkg::*;
#(
	parameter int BAUD_DIV = 52
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register bus
	input wire async_serial_pkg::apb_req_t apbReq,
	output async_serial_pkg::apb_rsp_t apbRsp,
	// System state
	input wire logic waitMode,
	input wire logic stopMode,
	input wire logic dbgBreak,
	input wire logic breakClearEn,
	// Port logic when the module is off
	input wire logic gpioOutTwo,
	input wire logic gpioOutThree,
	input wire logic dirBitTwo,
	input wire logic dirBitThree,
	output logic portInTwo,
	output logic portInThree,
	// Pins
	input wire logic pinTwoIn,
	output async_serial_pkg::od_pin_t pinTwo,
	input wire logic pinThreeIn,
	output async_serial_pkg::od_pin_t pinThree,
	// Requests
	output logic rxIrq,
	output logic errIrq,
	output logic txIrq,
	output logic wakeReq
);
	import async_serial_pkg::*;

	if (BAUD_DIV < 1 || BAUD_DIV > 65536) begin : g_bad_div
		$error("BAUD_DIV out of range");
	end

	localparam logic [15:0] DIV_RELOAD = 16'(BAUD_DIV - 1);

	typedef struct packed {
		logic [2:0] rxPinSync;
		logic [2:0] txPinSync;
		logic rxLine;
		logic txPinLine;
		logic [7:0] ctrlOne;
		logic [7:0] ctrlTwo;
		logic [7:0] ctrlThree;
		logic [7:0] status;
		logic [7:0] clearArm;
		logic [8:0] rxData;
		logic [8:0] rxBits;
		rx_state_t rxState;
		logic [3:0] rxRt;
		logic [3:0] bitIdx;
		logic [1:0] smp;
		logic rxNoise;
		logic rxPrev;
		logic [3:0] idleRt;
		logic [3:0] idleBits;
		logic idleArm;
		tx_state_t txState;
		logic [10:0] txShift;
		logic [3:0] txCnt;
		logic [3:0] txRt;
		logic [7:0] txBuf;
		logic txLevel;
		logic [15:0] baudCnt;
		logic rtTick;
		logic pinTwoOe;
		logic pinThreeOe;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic rxIrq;
		logic errIrq;
		logic txIrq;
		logic wakeReq;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [1:0] rstPipe_r;
	logic rstn;
	logic charDone, charMsb, stopLow, idleFire, idleWake, protect, doAcc, bitNow, noisy;
	logic enabled, nineBit, standby, rxIn, parErr, rxOn, txPar;
	logic [3:0] lastIdx, idleLimit;
	logic [8:0] frameBits;
	logic [7:0] rdVal;
	logic unmapped;

	// Reset release is synchronous so that no flop leaves reset on a different edge
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rstPipe_r <= 2'h0;
		end else begin
			rstPipe_r <= {rstPipe_r[0], 1'b1};
		end
	end
	assign rstn = rstPipe_r[1];

	always_comb begin
		st_nxt = st_r;
		charDone = 1'b0;
		charMsb = 1'b0;
		stopLow = 1'b0;
		idleFire = 1'b0;
		idleWake = 1'b0;
		bitNow = 1'b0;
		noisy = 1'b0;
		parErr = 1'b0;
		rdVal = 8'h00;
		unmapped = 1'b0;
		txPar = 1'b0;
		enabled = st_r.ctrlOne[MODULE_ENABLE_BIT];
		nineBit = st_r.ctrlOne[CHAR_NINE_BIT];
		standby = st_r.ctrlTwo[RX_STANDBY_BIT];
		lastIdx = nineBit ? LAST_IDX_LONG : LAST_IDX_SHORT;
		idleLimit = nineBit ? IDLE_BITS_LONG : IDLE_BITS_SHORT;
		frameBits = nineBit ? st_r.rxBits : {1'b0, st_r.rxBits[7:0]};
		protect = dbgBreak && !breakClearEn;

		// Pin synchronisers: a level counts once the last two stages agree
		st_nxt.rxPinSync = {st_r.rxPinSync[1:0], pinThreeIn};
		st_nxt.txPinSync = {st_r.txPinSync[1:0], pinTwoIn};
		if (st_r.rxPinSync[1] == st_r.rxPinSync[2]) begin
			st_nxt.rxLine = st_r.rxPinSync[2];
		end
		if (st_r.txPinSync[1] == st_r.txPinSync[2]) begin
			st_nxt.txPinLine = st_r.txPinSync[2];
		end
		rxIn = st_r.ctrlOne[LOOPBACK_BIT] ? st_r.txLevel : st_r.rxLine;

		// Bus: one wait state; data and error are prepared in that cycle
		st_nxt.pready = apbReq.psel && apbReq.penable && !st_r.pready;
		st_nxt.prdata = 32'h0000_0000;
		st_nxt.pslverr = 1'b0;
		case (apbReq.paddr)
			OFS_CTRL_ONE: rdVal = st_r.ctrlOne;
			OFS_CTRL_TWO: rdVal = st_r.ctrlTwo;
			OFS_CTRL_THREE: rdVal = st_r.ctrlThree;
			OFS_STATUS_ONE: rdVal = st_r.status;
			OFS_DATA: rdVal = st_r.rxData[7:0];
			default: unmapped = 1'b1;
		endcase
		if (st_nxt.pready) begin
			st_nxt.pslverr = unmapped || waitMode;
			st_nxt.prdata = st_nxt.pslverr ? 32'h0000_0000 : {24'h00_0000, rdVal};
		end
		doAcc = st_r.pready && apbReq.psel && apbReq.penable && !st_r.pslverr;
		if (doAcc && apbReq.pwrite) begin
			case (apbReq.paddr)
				OFS_CTRL_ONE: st_nxt.ctrlOne = apbReq.pwdata[7:0];
				OFS_CTRL_TWO: begin
					st_nxt.ctrlTwo = apbReq.pwdata[7:0];
					// Enables of both directions only move while the module is on
					if (!enabled) begin
						st_nxt.ctrlTwo[TX_ENABLE_BIT] = st_r.ctrlTwo[TX_ENABLE_BIT];
						st_nxt.ctrlTwo[RX_ENABLE_BIT] = st_r.ctrlTwo[RX_ENABLE_BIT];
					end
				end
				OFS_CTRL_THREE: begin
					st_nxt.ctrlThree = (st_r.ctrlThree & ~CTRL_THREE_WMASK) | (apbReq.pwdata[7:0] & CTRL_THREE_WMASK);
				end
				OFS_DATA: begin
					if (enabled) begin
						st_nxt.txBuf = apbReq.pwdata[7:0];
						st_nxt.status[TX_EMPTY_FLAG] = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (doAcc && !protect) begin
			if (!apbReq.pwrite && apbReq.paddr == OFS_STATUS_ONE) begin
				st_nxt.clearArm = st_r.status & RX_FLAG_MASK;
			end
			if (apbReq.paddr == OFS_DATA) begin
				// Start from the next value so that a transmit-buffer write in this cycle keeps its flag change
				st_nxt.status = st_nxt.status & ~st_r.clearArm;
				st_nxt.clearArm = 8'h00;
			end
		end

		// Divider for the oversampling tick; frozen in stop mode, state kept
		st_nxt.rtTick = 1'b0;
		if (enabled && !stopMode) begin
			if (st_r.baudCnt == 16'h0000) begin
				st_nxt.baudCnt = DIV_RELOAD;
				st_nxt.rtTick = 1'b1;
			end else begin
				st_nxt.baudCnt = st_r.baudCnt - 16'h0001;
			end
		end

		if (st_r.rtTick && st_r.ctrlTwo[RX_ENABLE_BIT]) begin
			if (st_r.rxState != RX_IDLE) begin
				st_nxt.rxRt = st_r.rxRt + 4'h1;
				if (st_r.rxRt == SMP_FIRST) begin
					st_nxt.smp[0] = rxIn;
				end
				if (st_r.rxRt == SMP_SECOND) begin
					st_nxt.smp[1] = rxIn;
				end
			end
			if (st_r.rxRt == SMP_THIRD) begin
				bitNow = (st_r.smp[0] & st_r.smp[1]) | (st_r.smp[0] & rxIn) | (st_r.smp[1] & rxIn);
				noisy = !((st_r.smp[0] == st_r.smp[1]) && (st_r.smp[1] == rxIn));
			end
			unique case (st_r.rxState)
				RX_IDLE: begin
					st_nxt.rxPrev = rxIn;
					if (st_r.rxPrev && !rxIn) begin
						st_nxt.rxState = RX_START;
						st_nxt.rxRt = 4'h0;
						st_nxt.rxNoise = 1'b0;
						st_nxt.bitIdx = 4'h0;
						st_nxt.idleBits = 4'h0;
						st_nxt.idleRt = 4'h0;
						st_nxt.idleArm = 1'b1;
					end else if (rxIn) begin
						st_nxt.idleRt = st_r.idleRt + 4'h1;
						if (st_r.idleRt == RT_LAST && st_r.idleBits != IDLE_BITS_MAX) begin
							st_nxt.idleBits = st_r.idleBits + 4'h1;
						end
					end else begin
						st_nxt.idleRt = 4'h0;
						st_nxt.idleBits = 4'h0;
					end
					if (st_r.idleBits >= idleLimit) begin
						// Idle wake does not need a character first, so it can fire at once
						if (standby && !st_r.ctrlOne[WAKE_ADDR_BIT]) begin
							idleWake = 1'b1;
							st_nxt.ctrlTwo[RX_STANDBY_BIT] = 1'b0;
							st_nxt.idleArm = 1'b0;
						end else if (st_r.idleArm) begin
							idleFire = 1'b1;
							st_nxt.idleArm = 1'b0;
							if (!standby) begin
								st_nxt.status[LINE_IDLE_FLAG] = 1'b1;
							end
						end
					end
				end
				RX_START: begin
					if (st_r.rxRt == SMP_THIRD) begin
						if (bitNow) begin
							st_nxt.rxState = RX_IDLE;
							st_nxt.rxPrev = rxIn;
						end else begin
							st_nxt.rxNoise = noisy;
							st_nxt.rxState = RX_DATA;
						end
					end
				end
				RX_DATA: begin
					if (st_r.rxRt == SMP_THIRD) begin
						st_nxt.rxBits[st_r.bitIdx] = bitNow;
						st_nxt.rxNoise = st_r.rxNoise | noisy;
						// Counting from the start bit lets ones inside data look idle
						if (!st_r.ctrlOne[IDLE_COUNT_TYPE]) begin
							st_nxt.idleBits = bitNow ? st_r.idleBits + 4'h1 : 4'h0;
						end
						if (st_r.bitIdx == lastIdx) begin
							st_nxt.rxState = RX_STOP;
						end else begin
							st_nxt.bitIdx = st_r.bitIdx + 4'h1;
						end
					end
				end
				RX_STOP: begin
					if (st_r.rxRt == SMP_THIRD) begin
						charDone = 1'b1;
						stopLow = !bitNow;
						st_nxt.rxState = RX_IDLE;
						st_nxt.rxPrev = rxIn;
						st_nxt.idleRt = 4'h0;
						if (!st_r.ctrlOne[IDLE_COUNT_TYPE] && bitNow) begin
							st_nxt.idleBits = st_r.idleBits + 4'h1;
						end
					end
				end
			endcase
		end else if (!st_r.ctrlTwo[RX_ENABLE_BIT]) begin
			st_nxt.rxState = RX_IDLE;
		end

		if (charDone) begin
			charMsb = nineBit ? st_r.rxBits[8] : st_r.rxBits[7];
			parErr = st_r.ctrlOne[PARITY_ON_BIT] && ((^frameBits) != st_r.ctrlOne[PARITY_ODD_BIT]);
			if (!standby || (st_r.ctrlOne[WAKE_ADDR_BIT] && charMsb)) begin
				st_nxt.ctrlTwo[RX_STANDBY_BIT] = 1'b0;
				if (st_nxt.status[RX_FULL_FLAG]) begin
					st_nxt.status[OVERRUN_FLAG] = 1'b1;
				end else begin
					st_nxt.rxData = {nineBit ? st_r.rxBits[8] : st_r.rxBits[7], st_r.rxBits[7:0]};
					st_nxt.status[RX_FULL_FLAG] = 1'b1;
					st_nxt.status[NOISE_FLAG] = st_nxt.status[NOISE_FLAG] | st_r.rxNoise | noisy;
					st_nxt.status[FRAMING_ERR_FLAG] = st_nxt.status[FRAMING_ERR_FLAG] | stopLow;
					st_nxt.status[PARITY_ERR_FLAG] = st_nxt.status[PARITY_ERR_FLAG] | parErr;
				end
			end
		end
		st_nxt.ctrlThree[RX_NINTH_BIT] = st_nxt.rxData[8];

		if (st_r.rtTick) begin
			unique case (st_r.txState)
				TX_IDLE: begin
					if (st_r.ctrlTwo[TX_ENABLE_BIT] && !st_r.status[TX_EMPTY_FLAG]) begin
						st_nxt.txState = TX_SHIFT;
						st_nxt.txRt = 4'h0;
						st_nxt.status[TX_EMPTY_FLAG] = 1'b1;
						st_nxt.status[TX_COMPLETE_FLAG] = 1'b0;
						if (nineBit) begin
							txPar = (^st_r.txBuf) ^ st_r.ctrlOne[PARITY_ODD_BIT];
							st_nxt.txShift = {1'b1, st_r.ctrlOne[PARITY_ON_BIT] ? txPar : st_r.ctrlThree[TX_NINTH_BIT],
								st_r.txBuf, 1'b0};
							st_nxt.txCnt = FRAME_LONG;
						end else begin
							txPar = (^st_r.txBuf[6:0]) ^ st_r.ctrlOne[PARITY_ODD_BIT];
							st_nxt.txShift = {2'h3, st_r.ctrlOne[PARITY_ON_BIT] ? txPar : st_r.txBuf[7],
								st_r.txBuf[6:0], 1'b0};
							st_nxt.txCnt = FRAME_SHORT;
						end
					end
				end
				TX_SHIFT: begin
					st_nxt.txRt = st_r.txRt + 4'h1;
					if (st_r.txRt == RT_LAST) begin
						st_nxt.txShift = {1'b1, st_r.txShift[10:1]};
						st_nxt.txCnt = st_r.txCnt - 4'h1;
						if (st_r.txCnt == 4'h1) begin
							st_nxt.txState = TX_IDLE;
							st_nxt.status[TX_COMPLETE_FLAG] = 1'b1;
						end
					end
				end
			endcase
		end

		if (!st_nxt.ctrlOne[MODULE_ENABLE_BIT]) begin
			st_nxt.status[TX_EMPTY_FLAG] = 1'b1;
			st_nxt.status[TX_COMPLETE_FLAG] = 1'b1;
			st_nxt.txState = TX_IDLE;
			st_nxt.rxState = RX_IDLE;
			st_nxt.baudCnt = 16'h0000;
		end
		// Inversion applies to the idle level too
		st_nxt.txLevel = ((st_nxt.txState == TX_SHIFT) ? st_nxt.txShift[0] : 1'b1) ^ st_nxt.ctrlOne[TX_INVERT_BIT];

		rxOn = st_nxt.ctrlOne[MODULE_ENABLE_BIT] && !st_nxt.ctrlTwo[RX_STANDBY_BIT];
		st_nxt.rxIrq = rxOn && ((st_nxt.ctrlTwo[RX_FULL_IRQ_EN] && st_nxt.status[RX_FULL_FLAG]) ||
			(st_nxt.ctrlTwo[LINE_IDLE_IRQ_EN] && st_nxt.status[LINE_IDLE_FLAG]));
		st_nxt.errIrq = rxOn && |(st_nxt.ctrlThree[3:0] & st_nxt.status[3:0]);
		st_nxt.txIrq = st_nxt.ctrlOne[MODULE_ENABLE_BIT] &&
			((st_nxt.ctrlTwo[TX_EMPTY_IRQ_EN] && st_nxt.status[TX_EMPTY_FLAG]) ||
			(st_nxt.ctrlTwo[TX_DONE_IRQ_EN] && st_nxt.status[TX_COMPLETE_FLAG]));
		st_nxt.wakeReq = waitMode && (st_nxt.rxIrq || st_nxt.errIrq || st_nxt.txIrq);
		// Open drain: the pin is only ever pulled low
		st_nxt.pinTwoOe = st_nxt.ctrlOne[MODULE_ENABLE_BIT] ? !st_nxt.txLevel : (dirBitTwo && !gpioOutTwo);
		st_nxt.pinThreeOe = st_nxt.ctrlOne[MODULE_ENABLE_BIT] ? 1'b0 : (dirBitThree && !gpioOutThree);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.ctrlOne <= CTRL_ONE_RESET;
			st_r.ctrlTwo <= CTRL_TWO_RESET;
			st_r.ctrlThree <= CTRL_THREE_RESET;
			st_r.status <= STATUS_RESET;
			st_r.rxState <= RX_IDLE;
			st_r.txState <= TX_IDLE;
			st_r.rxPinSync <= 3'h7;
			st_r.txPinSync <= 3'h7;
			st_r.rxLine <= 1'b1;
			st_r.txPinLine <= 1'b1;
			st_r.rxPrev <= 1'b1;
			st_r.txShift <= 11'h7FF;
			st_r.txLevel <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign apbRsp = '{pready: st_r.pready, prdata: st_r.prdata, pslverr: st_r.pslverr};
	assign pinTwo = '{out: 1'b0, oe: st_r.pinTwoOe};
	assign pinThree = '{out: 1'b0, oe: st_r.pinThreeOe};
	assign portInTwo = st_r.txPinLine;
	assign portInThree = st_r.rxLine;
	assign rxIrq = st_r.rxIrq;
	assign errIrq = st_r.errIrq;
	assign txIrq = st_r.txIrq;
	assign wakeReq = st_r.wakeReq;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_standby_quiet: assert property (st_r.ctrlTwo[RX_STANDBY_BIT] |-> !st_r.rxIrq && !st_r.errIrq)
		else $error("receiver request raised in standby");
	chk_addr_wake: assert property (
		charDone && standby && st_r.ctrlOne[WAKE_ADDR_BIT] && charMsb
		|=> !st_r.ctrlTwo[RX_STANDBY_BIT] && st_r.status[RX_FULL_FLAG])
		else $error("address mark did not wake receiver");
	chk_idle_wake: assert property (idleWake && !st_r.status[LINE_IDLE_FLAG]
		|=> !st_r.ctrlTwo[RX_STANDBY_BIT] && !st_r.status[LINE_IDLE_FLAG])
		else $error("idle wake wrong");
	chk_idle_type: assert property (st_r.ctrlOne[IDLE_COUNT_TYPE] && $stable(st_r.ctrlOne) &&
		st_r.rxState == RX_DATA && $past(st_r.rxState) != RX_IDLE |-> st_r.idleBits == 4'h0)
		else $error("idle counted inside frame");
	chk_rxfull_irq: assert property (st_r.status[RX_FULL_FLAG] && st_r.ctrlTwo[RX_FULL_IRQ_EN] &&
		st_r.ctrlOne[MODULE_ENABLE_BIT] && !st_r.ctrlTwo[RX_STANDBY_BIT] |-> st_r.rxIrq)
		else $error("receive-full request missing");
	chk_idle_flag: assert property (idleFire && !standby |-> st_r.idleBits >= idleLimit ##1
		st_r.status[LINE_IDLE_FLAG])
		else $error("idle flag not set");
	chk_overrun_keep: assert property (charDone && st_r.status[RX_FULL_FLAG] && !st_r.clearArm[RX_FULL_FLAG] &&
		!standby |=> st_r.status[OVERRUN_FLAG] && $stable(st_r.rxData))
		else $error("overrun handling wrong");
	chk_framing_same: assert property (charDone && stopLow && !st_r.status[RX_FULL_FLAG] &&
		!standby |=> st_r.status[FRAMING_ERR_FLAG] && st_r.status[RX_FULL_FLAG])
		else $error("framing flag not with receive-full");
	chk_clear_guard: assert property ($fell(st_r.status[RX_FULL_FLAG]) |-> !$past(protect))
		else $error("flag cleared during protected break");
	chk_tx_disabled: assert property (!st_r.ctrlOne[MODULE_ENABLE_BIT] |->
		st_r.status[TX_EMPTY_FLAG] && st_r.status[TX_COMPLETE_FLAG] && !st_r.txIrq)
		else $error("disabled transmitter state wrong");
	chk_pin_takeover: assert property (st_r.ctrlOne[MODULE_ENABLE_BIT] |->
		!st_r.pinThreeOe && (st_r.pinTwoOe == !st_r.txLevel))
		else $error("pin takeover wrong");
endmodule : async_serial_rx_wakeup_ctrl

// ===== logic/async_serial_pkg.sv
package async_serial_pkg;
	localparam int ADDR_W = 8;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL_THREE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS_ONE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h10;

	// serial_control_one fields
	localparam int LOOPBACK_BIT = 7;
	localparam int MODULE_ENABLE_BIT = 6;
	localparam int TX_INVERT_BIT = 5;
	localparam int CHAR_NINE_BIT = 4;
	localparam int WAKE_ADDR_BIT = 3;
	localparam int IDLE_COUNT_TYPE = 2;
	localparam int PARITY_ON_BIT = 1;
	localparam int PARITY_ODD_BIT = 0;
	// serial_control_two fields
	localparam int TX_EMPTY_IRQ_EN = 7;
	localparam int TX_DONE_IRQ_EN = 6;
	localparam int RX_FULL_IRQ_EN = 5;
	localparam int LINE_IDLE_IRQ_EN = 4;
	localparam int TX_ENABLE_BIT = 3;
	localparam int RX_ENABLE_BIT = 2;
	localparam int RX_STANDBY_BIT = 1;
	localparam int SEND_BREAK_BIT = 0;
	// serial_control_three fields
	localparam int RX_NINTH_BIT = 7;
	localparam int TX_NINTH_BIT = 6;
	localparam int OVERRUN_IRQ_EN = 3;
	localparam int NOISE_IRQ_EN = 2;
	localparam int FRAMING_IRQ_EN = 1;
	localparam int PARITY_IRQ_EN = 0;
	localparam logic [7:0] CTRL_THREE_WMASK = 8'h4F;
	// serial_status_one fields
	localparam int TX_EMPTY_FLAG = 7;
	localparam int TX_COMPLETE_FLAG = 6;
	localparam int RX_FULL_FLAG = 5;
	localparam int LINE_IDLE_FLAG = 4;
	localparam int OVERRUN_FLAG = 3;
	localparam int NOISE_FLAG = 2;
	localparam int FRAMING_ERR_FLAG = 1;
	localparam int PARITY_ERR_FLAG = 0;
	localparam logic [7:0] RX_FLAG_MASK = 8'h3F;

	// Reset values
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
	localparam logic [7:0] CTRL_THREE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'hC0;

	// Oversampling: 16 ticks a bit, majority of ticks 7, 8 and 9
	localparam logic [3:0] SMP_FIRST = 4'h7;
	localparam logic [3:0] SMP_SECOND = 4'h8;
	localparam logic [3:0] SMP_THIRD = 4'h9;
	localparam logic [3:0] RT_LAST = 4'hF;
	localparam logic [3:0] LAST_IDX_SHORT = 4'h7;
	localparam logic [3:0] LAST_IDX_LONG = 4'h8;
	localparam logic [3:0] IDLE_BITS_SHORT = 4'hA;
	localparam logic [3:0] IDLE_BITS_LONG = 4'hB;
	localparam logic [3:0] IDLE_BITS_MAX = 4'hF;
	localparam logic [3:0] FRAME_SHORT = 4'hA;
	localparam logic [3:0] FRAME_LONG = 4'hB;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SHIFT = 2'h2
	} tx_state_t;
endpackage : async_serial_pkg

// ===== tb/serial_line_tx.sv
`timescale 1ns/1ps
module serial_line_tx #(
	parameter int BIT_CLKS = 16
) (
	// Clock
	input wire logic clock,
	// Serial line
	output logic line
);
	initial line = 1'b1;
	// One frame: start, 8 data bits lsb first, chosen stop level, then one idle bit
	task automatic send(input logic [7:0] data, input logic stopBit);
		logic [9:0] frame;
		frame = {stopBit, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line <= frame[i];
			repeat (BIT_CLKS) @(posedge clock);
		end
		// Released line goes back to the pull-up level
		line <= 1'b1;
		repeat (BIT_CLKS) @(posedge clock);
	endtask : send
endmodule : serial_line_tx

// ===== tb/async_serial_rx_wakeup_ctrl_bench.sv
`timescale 1ns/1ps
module async_serial_rx_wakeup_ctrl_bench;
	import async_serial_pkg::*;
	logic clock, resetn, waitMode, stopMode, dbgBreak, breakClearEn, rxLine;
	logic gpioOutTwo, gpioOutThree, dirBitTwo, dirBitThree;
	logic portInTwo, portInThree, rxIrq, errIrq, txIrq, wakeReq, err;
	logic [31:0] rd;
	apb_req_t apbReq;
	apb_rsp_t apbRsp;
	od_pin_t pinTwo, pinThree;
	int fails, n_checks;
	typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
	row_t rows[4] = '{'{OFS_CTRL_ONE, 32'h0, 1'b0}, '{OFS_CTRL_TWO, 32'h0, 1'b0},
		'{OFS_STATUS_ONE, 32'hC0, 1'b0}, '{8'h14, 32'h0, 1'b1}};
	async_serial_rx_wakeup_ctrl #(.BAUD_DIV(1)) i_dut (.clock(clock), .resetn(resetn), .apbReq(apbReq),
		.apbRsp(apbRsp), .waitMode(waitMode), .stopMode(stopMode), .dbgBreak(dbgBreak),
		.breakClearEn(breakClearEn), .gpioOutTwo(gpioOutTwo), .gpioOutThree(gpioOutThree),
		.dirBitTwo(dirBitTwo), .dirBitThree(dirBitThree), .portInTwo(portInTwo), .portInThree(portInThree),
		.pinTwoIn(pinTwo.oe ? 1'b0 : 1'b1), .pinTwo(pinTwo), .pinThreeIn(rxLine & !pinThree.oe),
		.pinThree(pinThree), .rxIrq(rxIrq), .errIrq(errIrq), .txIrq(txIrq), .wakeReq(wakeReq));
	serial_line_tx #(.BIT_CLKS(16)) i_far (.clock(clock), .line(rxLine));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Request held until pready is sampled high, then released
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		apbReq <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			summarize();
		end
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask : apb
	task automatic status(input string nm, input logic [7:0] mask, input logic [7:0] exp);
		apb(1'b0, OFS_STATUS_ONE, 32'h0);
		check(nm, rd & {24'h0, mask}, {24'h0, exp});
	endtask : status
	initial begin
		{resetn, waitMode, stopMode, dbgBreak, breakClearEn} = '0;
		{gpioOutTwo, gpioOutThree, dirBitTwo, dirBitThree} = '0;
		apbReq = '0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			check("reset read", {rd[30:0], err}, {rows[i].d[30:0], rows[i].e});
		end
		$display("test reset values done");
		apb(1'b1, OFS_CTRL_ONE, 32'h40);
		apb(1'b1, OFS_CTRL_TWO, 32'h3C);
		apb(1'b1, OFS_CTRL_THREE, 32'h02);
		check("tx pin idle", pinTwo.oe, 1'b0);
		apb(1'b1, OFS_CTRL_ONE, 32'h60);
		@(negedge clock);
		check("tx pin inverted idle", pinTwo.oe, 1'b1);
		apb(1'b1, OFS_CTRL_ONE, 32'h40);
		$display("test pins done");
		i_far.send(8'h55, 1'b1);
		check("rx irq", rxIrq, 1'b1);
		status("rx full", 8'h2F, 8'h20);
		apb(1'b0, OFS_DATA, 32'h0);
		check("rx data", rd, 32'h55);
		status("rx full cleared", 8'h20, 8'h00);
		repeat (192) @(posedge clock);
		status("idle flag", 8'h10, 8'h10);
		check("idle irq", rxIrq, 1'b1);
		apb(1'b0, OFS_DATA, 32'h0);
		$display("test receive done");
		i_far.send(8'hA1, 1'b1);
		i_far.send(8'h3C, 1'b1);
		status("overrun", 8'h28, 8'h28);
		dbgBreak <= 1'b1;
		apb(1'b0, OFS_DATA, 32'h0);
		check("old data kept", rd, 32'hA1);
		status("flag held in break", 8'h08, 8'h08);
		dbgBreak <= 1'b0;
		apb(1'b0, OFS_DATA, 32'h0);
		status("cleared after break", 8'h08, 8'h00);
		$display("test overrun done");
		i_far.send(8'h0F, 1'b0);
		check("framing irq", errIrq, 1'b1);
		status("framing", 8'h22, 8'h22);
		apb(1'b0, OFS_DATA, 32'h0);
		$display("test framing done");
		// Address-mark wake keeps a line that is already idle from waking the receiver; idle counted after stop
		apb(1'b1, OFS_CTRL_ONE, 32'h4C);
		apb(1'b1, OFS_CTRL_TWO, 32'h2E);
		i_far.send(8'h12, 1'b1);
		check("standby masks irq", rxIrq, 1'b0);
		apb(1'b0, OFS_CTRL_TWO, 32'h0);
		check("still standby", rd, 32'h2E);
		i_far.send(8'h92, 1'b1);
		apb(1'b0, OFS_CTRL_TWO, 32'h0);
		check("address wake", rd, 32'h2C);
		status("wake sets full", 8'h20, 8'h20);
		$display("test wakeup done");
		waitMode <= 1'b1;
		apb(1'b0, OFS_CTRL_ONE, 32'h0);
		check("wait refuses", err, 1'b1);
		check("wait wakeup request", wakeReq, 1'b1);
		waitMode <= 1'b0;
		$display("test wait done");
		// Loop: the transmitter's own frame comes back through the receiver
		apb(1'b1, OFS_CTRL_ONE, 32'hC0);
		status("full before loop", 8'h20, 8'h20);
		apb(1'b1, OFS_DATA, 32'h5A);
		repeat (8) @(posedge clock);
		check("tx start bit on pin", pinTwo.oe, 1'b1);
		repeat (200) @(posedge clock);
		status("loop full", 8'h2F, 8'h20);
		apb(1'b0, OFS_DATA, 32'h0);
		check("loop data", rd, 32'h5A);
		$display("test loop done");
		apb(1'b1, OFS_CTRL_TWO, 32'hAC);
		apb(1'b1, OFS_DATA, 32'h33);
		repeat (4) @(posedge clock);
		check("tx empty irq", txIrq, 1'b1);
		apb(1'b1, OFS_CTRL_ONE, 32'h00);
		@(negedge clock);
		check("disable masks tx irq", txIrq, 1'b0);
		status("disable tx flags", 8'hC0, 8'hC0);
		{dirBitTwo, dirBitThree} <= 2'b11;
		repeat (8) @(posedge clock);
		check("tx pin as port", pinTwo.oe, 1'b1);
		check("tx pin level", portInTwo, 1'b0);
		check("rx pin as port", pinThree.oe, 1'b1);
		check("rx pin level", portInThree, 1'b0);
		{dirBitTwo, dirBitThree} <= 2'b00;
		$display("test disable done");
		// Reset in mid-run with loop, enable and inversion all set
		apb(1'b1, OFS_CTRL_ONE, 32'hE0);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			check("mid-run reset read", {rd[30:0], err}, {rows[i].d[30:0], rows[i].e});
		end
		$display("test mid-run reset done");
		summarize();
	end
endmodule : async_serial_rx_wakeup_ctrl_bench
